// ===== core/quirk_params.svh
// Offsets, field positions, masks and reset values of the emulator register bank.
// Assumes inclusion by bare name from the package and the port monitor.
`ifndef QUIRK_PARAMS_SVH
`define QUIRK_PARAMS_SVH

`define REG_COUNT 17
`define IDX_W 5

// Register indices; the APB byte address is four times the index
`define OFF_PIN_FUNCTION_SELECT_ONE 16'hffe0
`define OFF_PIN_FUNCTION_SELECT_FIVE 16'hffe1
`define OFF_PIN_FUNCTION_SELECT_THREE 16'hffe2
`define OFF_PORT_DIRECTION_ONE 16'hffe4
`define OFF_PORT_DIRECTION_TWO 16'hffe5
`define OFF_PORT_DIRECTION_SEVEN 16'hffea
`define OFF_PORT_DIRECTION_EIGHT 16'hffeb
`define OFF_WATCHDOG_CONTROL_STATUS 16'hffc0
`define OFF_SYSTEM_CONTROL_ONE 16'hfff0
`define OFF_SYSTEM_CONTROL_TWO 16'hfff1
`define OFF_INTERRUPT_ENABLE_ONE 16'hfff4
`define OFF_INTERRUPT_ENABLE_TWO 16'hfff5
`define OFF_INTERRUPT_REQUEST_ONE 16'hfff6
`define OFF_INTERRUPT_REQUEST_TWO 16'hfff7
`define OFF_MODULE_STANDBY_ONE 16'hfff9
`define OFF_MODULE_STANDBY_TWO 16'hfffa
`define OFF_MODULE_STANDBY_THREE 16'hfffb
`define OFF_RESERVED_WRITE_STATUS 16'hff00

// Addresses with no storage behind them
`define OFF_LOW_VOLTAGE_DETECT_CONTROL 16'hf730
`define OFF_LOW_VOLTAGE_DETECT_STATUS 16'hf731
`define OFF_FLASH_MODE_CONTROL_ONE 16'hf790
`define OFF_FLASH_MODE_CONTROL_TWO 16'hf791
`define OFF_FLASH_POWER_CONTROL 16'hf792
`define OFF_FLASH_BLOCK_SELECT 16'hf793
`define OFF_FLASH_ACCESS_ENABLE 16'hf79b

// Bits software must write as zero
`define MASK_PIN_FUNCTION_SELECT_ONE 8'h01
`define MASK_PIN_FUNCTION_SELECT_FIVE 8'hc0
`define MASK_PIN_FUNCTION_SELECT_THREE 8'he0
`define MASK_PORT_DIRECTION_ONE 8'h08
`define MASK_PORT_DIRECTION_TWO 8'he0
`define MASK_PORT_DIRECTION_SEVEN 8'h88
`define MASK_PORT_DIRECTION_EIGHT 8'h1f
`define MASK_SYSTEM_CONTROL_ONE 8'h08
`define MASK_SYSTEM_CONTROL_TWO 8'h40
`define MASK_INTERRUPT_ENABLE_ONE 8'h40
`define MASK_INTERRUPT_ENABLE_TWO 8'hc0
`define MASK_MODULE_STANDBY_ONE 8'h85
`define MASK_MODULE_STANDBY_TWO 8'h68
`define MASK_MODULE_STANDBY_THREE 8'h01
`define MASK_NONE 8'h00

`define REG_RESET 8'h00
`define ABSENT_READ 8'h00
`define WDT_COUNT_ENABLE_BIT 2
`define RSV_STICKY_BIT 7

`endif

// ===== core/quirk_pkg.sv
// Types shared by the emulator register bank and its surroundings.
// Assumes quirk_params.svh is on the include path.
`include "quirk_params.svh"

package quirk_pkg;

	typedef logic [7:0] byte_t;

	typedef struct packed {
		byte_t pin_function_select_one;
		byte_t pin_function_select_five;
		byte_t pin_function_select_three;
		byte_t port_direction_one;
		byte_t port_direction_two;
		byte_t port_direction_seven;
		byte_t port_direction_eight;
		byte_t watchdog_control_status;
		byte_t system_control_one;
		byte_t system_control_two;
		byte_t interrupt_enable_one;
		byte_t interrupt_enable_two;
		byte_t interrupt_request_one;
		byte_t interrupt_request_two;
		byte_t module_standby_one;
		byte_t module_standby_two;
		byte_t module_standby_three;
	} reg_bank_t;

endpackage

// ===== core/emulator_register_quirks.sv
// Peripheral control register bank as the emulation target sees it, on an APB slave port.
// Assumes an APB master on clk; all register outputs feed logic on the same clock.
`timescale 1ns/1ps

module emulator_register_quirks
	import quirk_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output reg_bank_t reg_bank,
	output logic watchdog_count_en
);

	function automatic logic [15:0] offset_of(input int unsigned i);
		unique case (i)
			0: offset_of = `OFF_PIN_FUNCTION_SELECT_ONE;
			1: offset_of = `OFF_PIN_FUNCTION_SELECT_FIVE;
			2: offset_of = `OFF_PIN_FUNCTION_SELECT_THREE;
			3: offset_of = `OFF_PORT_DIRECTION_ONE;
			4: offset_of = `OFF_PORT_DIRECTION_TWO;
			5: offset_of = `OFF_PORT_DIRECTION_SEVEN;
			6: offset_of = `OFF_PORT_DIRECTION_EIGHT;
			7: offset_of = `OFF_WATCHDOG_CONTROL_STATUS;
			8: offset_of = `OFF_SYSTEM_CONTROL_ONE;
			9: offset_of = `OFF_SYSTEM_CONTROL_TWO;
			10: offset_of = `OFF_INTERRUPT_ENABLE_ONE;
			11: offset_of = `OFF_INTERRUPT_ENABLE_TWO;
			12: offset_of = `OFF_INTERRUPT_REQUEST_ONE;
			13: offset_of = `OFF_INTERRUPT_REQUEST_TWO;
			14: offset_of = `OFF_MODULE_STANDBY_ONE;
			15: offset_of = `OFF_MODULE_STANDBY_TWO;
			default: offset_of = `OFF_MODULE_STANDBY_THREE;
		endcase
	endfunction

	// Bits that must be written as zero; flagged in the status register, never forced
	function automatic logic [7:0] zero_mask_of(input int unsigned i);
		unique case (i)
			0: zero_mask_of = `MASK_PIN_FUNCTION_SELECT_ONE;
			1: zero_mask_of = `MASK_PIN_FUNCTION_SELECT_FIVE;
			2: zero_mask_of = `MASK_PIN_FUNCTION_SELECT_THREE;
			3: zero_mask_of = `MASK_PORT_DIRECTION_ONE;
			4: zero_mask_of = `MASK_PORT_DIRECTION_TWO;
			5: zero_mask_of = `MASK_PORT_DIRECTION_SEVEN;
			6: zero_mask_of = `MASK_PORT_DIRECTION_EIGHT;
			8: zero_mask_of = `MASK_SYSTEM_CONTROL_ONE;
			9: zero_mask_of = `MASK_SYSTEM_CONTROL_TWO;
			10: zero_mask_of = `MASK_INTERRUPT_ENABLE_ONE;
			11: zero_mask_of = `MASK_INTERRUPT_ENABLE_TWO;
			14: zero_mask_of = `MASK_MODULE_STANDBY_ONE;
			15: zero_mask_of = `MASK_MODULE_STANDBY_TWO;
			16: zero_mask_of = `MASK_MODULE_STANDBY_THREE;
			default: zero_mask_of = `MASK_NONE;
		endcase
	endfunction

	function automatic logic is_absent(input logic [15:0] off);
		is_absent = (off == `OFF_LOW_VOLTAGE_DETECT_CONTROL)
			|| (off == `OFF_LOW_VOLTAGE_DETECT_STATUS)
			|| (off == `OFF_FLASH_MODE_CONTROL_ONE)
			|| (off == `OFF_FLASH_MODE_CONTROL_TWO)
			|| (off == `OFF_FLASH_POWER_CONTROL)
			|| (off == `OFF_FLASH_BLOCK_SELECT)
			|| (off == `OFF_FLASH_ACCESS_ENABLE);
	endfunction

	logic [7:0] regs [`REG_COUNT];
	logic [`REG_COUNT-1:0] hit;
	logic [`REG_COUNT-1:0] bad_write;
	logic addr_in_range;
	logic [15:0] addr_index;
	logic status_hit;
	logic absent_hit;
	logic answer_ready;
	logic access_done;
	logic write_done;
	logic byte_write;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;
	logic next_err;
	logic [7:0] rsv_status;
	logic any_bad;
	logic [`IDX_W-1:0] bad_index;

	// Word-aligned index decode; anything above the 16-bit index space is unmapped
	assign addr_in_range = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
	assign addr_index = paddr[17:2];
	assign status_hit = addr_in_range && (addr_index == `OFF_RESERVED_WRITE_STATUS);
	assign absent_hit = addr_in_range && is_absent(addr_index);

	// Read data is captured in the setup cycle, so the access phase answers at once
	assign pready = psel && penable && answer_ready && ce;
	assign access_done = pready;
	assign write_done = access_done && pwrite;
	assign byte_write = write_done && pstrb[0];
	assign wbyte = pwdata[7:0];

	genvar g;
	generate
		for (g = 0; g < `REG_COUNT; g++) begin : gen_reg
			assign hit[g] = addr_in_range && (addr_index == offset_of(g));
			assign bad_write[g] = byte_write && hit[g] && ((wbyte & zero_mask_of(g)) != 8'h00);

			// Every bit keeps what software wrote, reserved ones included
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					regs[g] <= `REG_RESET;
				end else if (ce && byte_write && hit[g]) begin
					regs[g] <= wbyte;
				end
			end
		end
	endgenerate

	always_comb begin
		bad_index = '0;
		for (int i = 0; i < `REG_COUNT; i++) begin
			if (bad_write[i]) begin
				bad_index = i[`IDX_W-1:0];
			end
		end
	end
	assign any_bad = |bad_write;

	// Sticky flag in bit 7, index of the last offending register in the low bits;
	// a new offence in the clearing cycle keeps the flag set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsv_status <= `REG_RESET;
		end else if (ce) begin
			if (any_bad) begin
				rsv_status <= {1'b1, 2'h0, bad_index};
			end else if (byte_write && status_hit && wbyte[`RSV_STICKY_BIT]) begin
				rsv_status[`RSV_STICKY_BIT] <= 1'b0;
			end
		end
	end

	always_comb begin
		next_rdata = 8'h00;
		next_err = 1'b1;
		if (status_hit) begin
			next_rdata = rsv_status;
			next_err = 1'b0;
		end else if (absent_hit) begin
			next_rdata = `ABSENT_READ;
			next_err = 1'b0;
		end else begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				if (hit[i]) begin
					next_rdata = regs[i];
					next_err = 1'b0;
				end
			end
		end
	end

	// Answer is prepared once per transfer and dropped when the transfer completes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			answer_ready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			if (access_done) begin
				answer_ready <= 1'b0;
			end else if (psel && !answer_ready) begin
				answer_ready <= 1'b1;
				prdata <= {24'h00_0000, pwrite ? 8'h00 : next_rdata};
				pslverr <= next_err;
			end
		end
	end

	assign reg_bank.pin_function_select_one = regs[0];
	assign reg_bank.pin_function_select_five = regs[1];
	assign reg_bank.pin_function_select_three = regs[2];
	assign reg_bank.port_direction_one = regs[3];
	assign reg_bank.port_direction_two = regs[4];
	assign reg_bank.port_direction_seven = regs[5];
	assign reg_bank.port_direction_eight = regs[6];
	assign reg_bank.watchdog_control_status = regs[7];
	assign reg_bank.system_control_one = regs[8];
	assign reg_bank.system_control_two = regs[9];
	assign reg_bank.interrupt_enable_one = regs[10];
	assign reg_bank.interrupt_enable_two = regs[11];
	assign reg_bank.interrupt_request_one = regs[12];
	assign reg_bank.interrupt_request_two = regs[13];
	assign reg_bank.module_standby_one = regs[14];
	assign reg_bank.module_standby_two = regs[15];
	assign reg_bank.module_standby_three = regs[16];

	// The watchdog stays idle after reset until software sets the bit
	assign watchdog_count_en = regs[7][`WDT_COUNT_ENABLE_BIT];

endmodule

// ===== tb/quirk_monitor.sv
// Port checker for the emulator register bank.
// Assumes it is bound to emulator_register_quirks.
`timescale 1ns/1ps
`include "quirk_params.svh"
module quirk_monitor
	import quirk_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire reg_bank_t reg_bank,
	input wire logic watchdog_count_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic acc;
	logic wr;
	logic [15:0] off;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && pstrb[0] && !pslverr;
	assign off = paddr[17:2];
	property p_rdata_upper; prdata[31:8] == 24'h0; endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("prdata upper bits set");
	property p_ready_cause; pready |-> psel && penable && ce; endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	property p_wdt_bit; watchdog_count_en == reg_bank.watchdog_control_status[2]; endproperty
	a_wdt_bit: assert property (p_wdt_bit) else $error("watchdog enable mismatch");
	property p_misalign; acc && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0; endproperty
	a_misalign: assert property (p_misalign) else $error("misaligned not refused");
	property p_pin1_store;
		wr && off == `OFF_PIN_FUNCTION_SELECT_ONE
		|=> {24'h0, reg_bank.pin_function_select_one} == ($past(pwdata) & 32'hff);
	endproperty
	a_pin1_store: assert property (p_pin1_store) else $error("pin select one not stored");
	property p_mst1_store;
		wr && off == `OFF_MODULE_STANDBY_ONE
		|=> {24'h0, reg_bank.module_standby_one} == ($past(pwdata) & 32'hff);
	endproperty
	a_mst1_store: assert property (p_mst1_store) else $error("standby one not stored");
	property p_absent_hold; acc && pwrite && off[15:8] == 8'hf7 |=> $stable(reg_bank); endproperty
	a_absent_hold: assert property (p_absent_hold) else $error("absent write changed bank");
	property p_read_ien2;
		acc && !pwrite && !pslverr && off == `OFF_INTERRUPT_ENABLE_TWO
		|-> prdata[7:0] == reg_bank.interrupt_enable_two;
	endproperty
	a_read_ien2: assert property (p_read_ien2) else $error("enable two readback wrong");
	c_write: cover property (wr);
	c_refused: cover property (acc && pslverr);
	c_wdt_on: cover property (watchdog_count_en);
endmodule

// ===== tb/emulator_register_quirks_tb.sv
// Self-checking bench for the emulator register bank over APB.
// Assumes quirk_pkg and quirk_monitor are compiled first.
`timescale 1ns/1ps
module emulator_register_quirks_tb
	import quirk_pkg::*;
;
	logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, watchdog_count_en, err;
	logic [31:0] paddr, pwdata, prdata, rd, seed;
	logic [3:0] pstrb;
	reg_bank_t reg_bank;
	logic [7:0] model [17];
	logic [15:0] offs [17] = '{16'hffe0, 16'hffe1, 16'hffe2, 16'hffe4, 16'hffe5, 16'hffea,
		16'hffeb, 16'hffc0, 16'hfff0, 16'hfff1, 16'hfff4, 16'hfff5, 16'hfff6, 16'hfff7,
		16'hfff9, 16'hfffa, 16'hfffb};
	// Must-be-zero bits are set on purpose: they must still be stored in full,
	// except on the port direction registers, which software keeps clean
	logic [7:0] mbz [17] = '{8'h01, 8'hc0, 8'he0, 8'h08, 8'he0, 8'h88, 8'h1f, 8'h00,
		8'h08, 8'h40, 8'h40, 8'hc0, 8'h00, 8'h00, 8'h85, 8'h68, 8'h01};
	logic [15:0] absent [7] = '{16'hf730, 16'hf731, 16'hf790, 16'hf791, 16'hf792,
		16'hf793, 16'hf79b};
	int failures, total_checks, cycles, i, p;
	emulator_register_quirks dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_bank(reg_bank),
		.watchdog_count_en(watchdog_count_en));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bank_chk();
		for (int k = 0; k < 17; k++) chk("bank byte", {24'h0, model[k]}, {24'h0, reg_bank[8*(16-k) +: 8]});
	endtask
	task automatic apb(input logic w, input logic [15:0] off, input logic [1:0] lo, input logic [7:0] d);
		seed = lfsr(seed);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0, off, lo};
		pwdata <= {seed[31:8], d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		foreach (model[k]) model[k] = 8'h00;
		@(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
		seed = 32'hec4a;
		ce = 1'b1;
		pstrb = 4'hf;
		@(posedge clk);
		do_reset();
		for (i = 0; i < 17; i++) begin
			apb(1'b0, offs[i], 2'b00, 8'h00);
			chk("reset read", 32'h0, rd);
		end
		for (p = 0; p < 2; p++) for (i = 0; i < 17; i++) begin
			seed = lfsr(seed);
			model[i] = seed[7:0] | mbz[i];
			if (i >= 3 && i <= 6) model[i] = model[i] & ~mbz[i];
			apb(1'b1, offs[i], 2'b00, model[i]);
			apb(1'b0, offs[i], 2'b00, 8'h00);
			chk("readback", {24'h0, model[i]}, rd);
			chk("mapped error", 32'h0, {31'h0, err});
			chk("watchdog enable", {31'h0, model[7][2]}, {31'h0, watchdog_count_en});
		end
		apb(1'b0, 16'hff00, 2'b00, 8'h00);
		chk("offence status", 32'h90, rd & 32'h9f);
		// Clearing the sticky flag leaves the index of the last offender in place
		apb(1'b1, 16'hff00, 2'b00, 8'h80);
		apb(1'b0, 16'hff00, 2'b00, 8'h00);
		chk("offence cleared", 32'h10, rd & 32'h9f);
		for (i = 0; i < 7; i++) begin
			apb(1'b1, absent[i], 2'b00, 8'hff);
			apb(1'b0, absent[i], 2'b00, 8'h00);
			chk("absent read", 32'h0, rd);
			chk("absent error", 32'h0, {31'h0, err});
		end
		bank_chk();
		apb(1'b1, 16'hffe0, 2'b01, 8'h5a);
		chk("misaligned error", 32'h1, {31'h0, err});
		apb(1'b1, 16'hffe3, 2'b00, 8'h5a);
		chk("unmapped error", 32'h1, {31'h0, err});
		pstrb <= 4'he;
		apb(1'b1, 16'hffe0, 2'b00, 8'h5a);
		pstrb <= 4'hf;
		bank_chk();
		model[7] = 8'h04;
		apb(1'b1, offs[7], 2'b00, model[7]);
		chk("watchdog count enable", 32'h1, {31'h0, watchdog_count_en});
		bank_chk();
		do_reset();
		bank_chk();
		chk("watchdog after reset", 32'h0, {31'h0, watchdog_count_en});
		tally_and_finish();
	end
endmodule
bind emulator_register_quirks quirk_monitor mon (.clk(clk), .rst_b(rst_b), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.reg_bank(reg_bank), .watchdog_count_en(watchdog_count_en));
